/* File: verilog/dkc_top.sv */
`timescale 1ns/1ps
// Behaviour
// - Latch low address byte from muxed bus at address strobe fall.
// - Answer microcontroller only when program-fetch strobe is high.
// - Drive register contents on bus while read strobe low and access valid.
// - Load addressed register at rising write strobe with valid access.
// - Interrupt output low while an enabled condition is pending.
// - Buffer RAM uses 16-bit address and 8-bit two-way data.
// - Bank select output is inverse of top buffer address bit.
// - Buffer write enable low during every buffer byte write.
// - Buffer output enable low during every buffer byte read.
// - Read gate output raised to start a disk read.
// - Write gate output held high for whole disk write.
// - Serial write data shifted out timed to our write clock output.
// - Serial read data sampled against the read clock input.
// - Legacy mark sync input establishes byte alignment of read data.
// - In ESDI mark sync pin becomes first-drive mark enable output.
// - Legacy mark gate output high while address mark written.
// - In ESDI mark gate pin is second-drive mark enable.
// - Program-selectable legacy or ESDI drive interface mode.
// - Two selectable checksum polynomials applied on the fly.
// - Reset output held at least 24 half-rate clock cycles.
// - Buffer manager packs bytes to words and unpacks words to bytes.
// - Half-rate clock output at half the core clock, even duty.
module dkc_top (
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic i_ce,
  input wire logic [7:0] i_mcu_muxed_addr_data,
  output logic [7:0] o_mcu_muxed_addr_data,
  output logic o_mcu_muxed_addr_data_oe,
  output logic [7:0] o_mcu_latched_addr,
  input wire logic i_address_latch_strobe,
  input wire logic i_program_fetch_strobe_n,
  input wire logic i_mcu_read_n,
  input wire logic i_mcu_write_n,
  output logic o_mcu_interrupt_n,
  input wire logic [7:0] i_buffer_data,
  output logic [7:0] o_buffer_data,
  output logic o_buffer_data_oe,
  output logic [15:0] o_buffer_addr,
  output logic o_upper_bank_select_n,
  output logic o_buffer_write_enable_n,
  output logic o_buffer_output_enable_n,
  input wire logic i_host_wr_valid,
  input wire logic [15:0] i_host_wr_word,
  output logic o_host_wr_ready,
  input wire logic i_host_rd_req,
  output logic [15:0] o_host_rd_word,
  output logic o_host_rd_valid,
  output logic o_disk_read_gate,
  output logic o_disk_write_gate,
  input wire logic i_disk_read_clock,
  input wire logic i_disk_read_serial,
  output logic o_disk_write_clock,
  output logic o_disk_write_serial,
  input wire logic i_mark_sync_pin,
  output logic o_mark_sync_pin,
  output logic o_mark_sync_pin_oe,
  output logic o_mark_gate_pin,
  output logic o_reset_output,
  output logic o_half_rate_clock
);

  typedef enum logic [2:0] {DKC_IDLE, DKC_WSET, DKC_WPULSE, DKC_WHOLD, DKC_RSTROBE} dkc_buf_state_t;

  function automatic logic dkc_access_ok(input logic program_fetch_strobe_n_n, input logic [7:0] addr);
    dkc_access_ok = program_fetch_strobe_n_n && (addr <= dkc_pkg::REG_LAST);
  endfunction

  function automatic logic [15:0] dkc_crc_byte(input logic [15:0] c, input logic [7:0] d, input logic [15:0] p);
    logic [15:0] r;
    r = c;
    for (int k = 7; k >= 0; k--) begin
      if (r[15] ^ d[k]) begin
        r = {r[14:0], 1'b0} ^ p;
      end else begin
        r = {r[14:0], 1'b0};
      end
    end
    dkc_crc_byte = r;
  endfunction

  // ---------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------
  logic [7:0] ad_s1_q, ad_s2_q, bd_s1_q, bd_s2_q;
  logic [2:0] ale_q, program_fetch_strobe_n_q, rd_q, wr_q, rxt_q;
  logic rx_tgl_l_q;

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      ad_s1_q <= 8'h00;
      ad_s2_q <= 8'h00;
      bd_s1_q <= 8'h00;
      bd_s2_q <= 8'h00;
      ale_q <= 3'h0;
      program_fetch_strobe_n_q <= 3'h0;
      rd_q <= 3'h7;
      wr_q <= 3'h7;
      rxt_q <= 3'h0;
    end else if (i_ce) begin
      ad_s1_q <= i_mcu_muxed_addr_data;
      ad_s2_q <= ad_s1_q;
      bd_s1_q <= i_buffer_data;
      bd_s2_q <= bd_s1_q;
      ale_q <= {ale_q[1:0], i_address_latch_strobe};
      program_fetch_strobe_n_q <= {program_fetch_strobe_n_q[1:0], i_program_fetch_strobe_n};
      rd_q <= {rd_q[1:0], i_mcu_read_n};
      wr_q <= {wr_q[1:0], i_mcu_write_n};
      rxt_q <= {rxt_q[1:0], rx_tgl_l_q};
    end
  end

  // ---------------------------------------------------------------
  // Microcontroller bus decode
  // ---------------------------------------------------------------
  logic [7:0] laddr_q, ctrl_q, tx_hold_q, rx_byte_q, rdata, buf_rbyte_q, mcu_wbyte_q;
  logic [1:0] int_en_q;
  logic [15:0] crc_q, buf_addr_q;
  logic wr_strobe, rd_end, rd_active, rx_ready_q, tx_full_q, rx_event;
  logic [7:0] rx_byte_l_q;
  dkc_buf_state_t bstate_q;

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      laddr_q <= 8'h00;
      o_mcu_latched_addr <= 8'h00;
    end else if (i_ce && ale_q[2] && !ale_q[1]) begin
      laddr_q <= ad_s2_q;
      o_mcu_latched_addr <= ad_s2_q;
    end
  end

  assign wr_strobe = wr_q[1] && !wr_q[2] && dkc_access_ok(program_fetch_strobe_n_q[1], laddr_q);
  assign rd_end = rd_q[1] && !rd_q[2] && dkc_access_ok(program_fetch_strobe_n_q[1], laddr_q);
  assign rd_active = !rd_q[1] && dkc_access_ok(program_fetch_strobe_n_q[1], laddr_q);

  always_comb begin
    case (laddr_q)
      dkc_pkg::REG_CTRL: rdata = ctrl_q;
      dkc_pkg::REG_STATUS: rdata = {4'h0, ctrl_q[dkc_pkg::CTRL_ESDI], tx_full_q, rx_ready_q, bstate_q != DKC_IDLE};
      dkc_pkg::REG_BUF_ADDR_LO: rdata = buf_addr_q[7:0];
      dkc_pkg::REG_BUF_ADDR_HI: rdata = buf_addr_q[15:8];
      dkc_pkg::REG_BUF_DATA: rdata = buf_rbyte_q;
      dkc_pkg::REG_DISK_TX: rdata = tx_hold_q;
      dkc_pkg::REG_DISK_RX: rdata = rx_byte_q;
      dkc_pkg::REG_INT_EN: rdata = {6'h00, int_en_q};
      dkc_pkg::REG_CRC_LO: rdata = crc_q[7:0];
      dkc_pkg::REG_CRC_HI: rdata = crc_q[15:8];
      default: rdata = 8'h00;
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      o_mcu_muxed_addr_data <= 8'h00;
      o_mcu_muxed_addr_data_oe <= 1'b0;
    end else if (i_ce) begin
      o_mcu_muxed_addr_data <= rdata;
      o_mcu_muxed_addr_data_oe <= rd_active;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      ctrl_q <= dkc_pkg::CTRL_RESET;
      int_en_q <= dkc_pkg::INT_EN_RESET;
    end else if (i_ce && wr_strobe) begin
      if (laddr_q == dkc_pkg::REG_CTRL) begin
        ctrl_q <= ad_s2_q;
      end
      if (laddr_q == dkc_pkg::REG_INT_EN) begin
        int_en_q <= ad_s2_q[1:0];
      end
    end
  end

  // ---------------------------------------------------------------
  // Disk receive, link clock domain
  // ---------------------------------------------------------------
  logic rg_l1_q, rg_l2_q, es_l1_q, es_l2_q, ms_l_q, aligned_l_q;
  logic [7:0] rx_sh_l_q;
  logic [2:0] rx_bit_l_q;

  always_ff @(posedge i_disk_read_clock) begin
    rg_l1_q <= o_disk_read_gate;
    rg_l2_q <= rg_l1_q;
    es_l1_q <= ctrl_q[dkc_pkg::CTRL_ESDI];
    es_l2_q <= es_l1_q;
    ms_l_q <= i_mark_sync_pin && !es_l2_q;
    if (!rg_l2_q) begin
      rx_bit_l_q <= 3'h0;
      aligned_l_q <= 1'b0;
      rx_tgl_l_q <= 1'b0;
    end else if (!es_l2_q && i_mark_sync_pin && !ms_l_q) begin
      rx_bit_l_q <= 3'h0;
      aligned_l_q <= 1'b1;
    end else begin
      rx_sh_l_q <= {rx_sh_l_q[6:0], i_disk_read_serial};
      rx_bit_l_q <= rx_bit_l_q + 3'h1;
      if (es_l2_q) begin
        aligned_l_q <= 1'b1;
      end
      if (rx_bit_l_q == 3'h7 && aligned_l_q) begin
        rx_byte_l_q <= {rx_sh_l_q[6:0], i_disk_read_serial};
        rx_tgl_l_q <= !rx_tgl_l_q;
      end
    end
  end

  // Toggle clears while gated off; that edge is ignored
  assign rx_event = (rxt_q[2] ^ rxt_q[1]) && o_disk_read_gate;

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      rx_byte_q <= 8'h00;
      rx_ready_q <= 1'b0;
    end else if (i_ce) begin
      if (rd_end && laddr_q == dkc_pkg::REG_DISK_RX) begin
        rx_ready_q <= 1'b0;
      end
      if (rx_event) begin
        rx_byte_q <= rx_byte_l_q;
        rx_ready_q <= 1'b1;
      end
    end
  end

  // ---------------------------------------------------------------
  // Disk transmit and drive pins
  // ---------------------------------------------------------------
  logic [2:0] wdiv_q, tx_bit_q;
  logic [7:0] tx_sh_q, tx_cur;
  logic tx_fall, tx_load;

  assign tx_fall = (wdiv_q == 3'h0) && o_disk_write_clock;
  assign tx_load = tx_fall && o_disk_write_gate && tx_bit_q == 3'h0;
  assign tx_cur = tx_full_q ? tx_hold_q : 8'h00;

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      wdiv_q <= dkc_pkg::WCLK_HALF_CYCLES - 3'h1;
      o_disk_write_clock <= 1'b0;
      o_disk_write_serial <= 1'b0;
      tx_bit_q <= 3'h0;
      tx_sh_q <= 8'h00;
    end else if (i_ce) begin
      wdiv_q <= (wdiv_q == 3'h0) ? dkc_pkg::WCLK_HALF_CYCLES - 3'h1 : wdiv_q - 3'h1;
      if (wdiv_q == 3'h0) begin
        o_disk_write_clock <= !o_disk_write_clock;
      end
      if (tx_fall) begin
        if (!o_disk_write_gate) begin
          o_disk_write_serial <= 1'b0;
          tx_bit_q <= 3'h0;
        end else if (tx_bit_q == 3'h0) begin
          o_disk_write_serial <= tx_cur[7];
          tx_sh_q <= {tx_cur[6:0], 1'b0};
          tx_bit_q <= 3'h1;
        end else begin
          o_disk_write_serial <= tx_sh_q[7];
          tx_sh_q <= {tx_sh_q[6:0], 1'b0};
          tx_bit_q <= tx_bit_q + 3'h1;
        end
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      tx_hold_q <= 8'h00;
      tx_full_q <= 1'b0;
    end else if (i_ce) begin
      if (tx_load) begin
        tx_full_q <= 1'b0;
      end
      if (wr_strobe && laddr_q == dkc_pkg::REG_DISK_TX) begin
        tx_hold_q <= ad_s2_q;
        tx_full_q <= 1'b1;
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      crc_q <= dkc_pkg::CRC_SEED;
    end else if (i_ce) begin
      if (wr_strobe && laddr_q == dkc_pkg::REG_CRC_LO) begin
        crc_q <= dkc_pkg::CRC_SEED;
      end else if (ctrl_q[dkc_pkg::CTRL_CRC_EN] && (rx_event || tx_load)) begin
        crc_q <= dkc_crc_byte(crc_q, rx_event ? rx_byte_l_q : tx_cur,
                              ctrl_q[dkc_pkg::CTRL_POLY_SEL] ? dkc_pkg::POLY_ALT : dkc_pkg::POLY_CCITT);
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      o_disk_read_gate <= 1'b0;
      o_disk_write_gate <= 1'b0;
      o_mark_sync_pin <= 1'b0;
      o_mark_sync_pin_oe <= 1'b0;
      o_mark_gate_pin <= 1'b0;
    end else if (i_ce) begin
      o_disk_read_gate <= ctrl_q[dkc_pkg::CTRL_READ_GATE];
      o_disk_write_gate <= ctrl_q[dkc_pkg::CTRL_WRITE_GATE];
      o_mark_sync_pin_oe <= ctrl_q[dkc_pkg::CTRL_ESDI];
      o_mark_sync_pin <= ctrl_q[dkc_pkg::CTRL_ESDI] && ctrl_q[dkc_pkg::CTRL_MARK_EN0];
      o_mark_gate_pin <= ctrl_q[dkc_pkg::CTRL_ESDI] ? ctrl_q[dkc_pkg::CTRL_MARK_EN1] :
                         ctrl_q[dkc_pkg::CTRL_MARK_WRITE] && ctrl_q[dkc_pkg::CTRL_WRITE_GATE];
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      o_mcu_interrupt_n <= 1'b1;
    end else if (i_ce) begin
      o_mcu_interrupt_n <= !((rx_ready_q && int_en_q[dkc_pkg::INT_EN_RX]) ||
                             (!tx_full_q && o_disk_write_gate && int_en_q[dkc_pkg::INT_EN_TX]));
    end
  end

  // ---------------------------------------------------------------
  // Buffer manager
  // ---------------------------------------------------------------
  logic [2:0] bcnt_q;
  logic [15:0] job_word_q;
  logic mcu_wr_pend_q, mcu_rd_pend_q, host_rd_pend_q, job_host_q, job_two_q, job_hi_q, take_any;

  assign take_any = mcu_wr_pend_q || mcu_rd_pend_q || host_rd_pend_q || (i_host_wr_valid && o_host_wr_ready);

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      bstate_q <= DKC_IDLE;
      bcnt_q <= 3'h0;
      buf_addr_q <= 16'h0000;
      buf_rbyte_q <= 8'h00;
      mcu_wbyte_q <= 8'h00;
      mcu_wr_pend_q <= 1'b0;
      mcu_rd_pend_q <= 1'b0;
      host_rd_pend_q <= 1'b0;
      job_host_q <= 1'b0;
      job_two_q <= 1'b0;
      job_hi_q <= 1'b0;
      job_word_q <= 16'h0000;
      o_buffer_data <= 8'h00;
      o_buffer_data_oe <= 1'b0;
      o_buffer_write_enable_n <= 1'b1;
      o_buffer_output_enable_n <= 1'b1;
      o_host_wr_ready <= 1'b0;
      o_host_rd_valid <= 1'b0;
      o_host_rd_word <= 16'h0000;
    end else if (i_ce) begin
      o_host_rd_valid <= 1'b0;
      o_host_wr_ready <= 1'b0;
      case (bstate_q)
        DKC_IDLE: begin
          bcnt_q <= 3'h0;
          if (mcu_wr_pend_q) begin
            mcu_wr_pend_q <= 1'b0;
            {job_host_q, job_two_q, job_hi_q} <= 3'h0;
            o_buffer_data <= mcu_wbyte_q;
            bstate_q <= DKC_WSET;
          end else if (mcu_rd_pend_q) begin
            mcu_rd_pend_q <= 1'b0;
            {job_host_q, job_two_q, job_hi_q} <= 3'h0;
            o_buffer_output_enable_n <= 1'b0;
            bstate_q <= DKC_RSTROBE;
          end else if (host_rd_pend_q) begin
            host_rd_pend_q <= 1'b0;
            {job_host_q, job_two_q, job_hi_q} <= 3'h6;
            o_buffer_output_enable_n <= 1'b0;
            bstate_q <= DKC_RSTROBE;
          end else if (i_host_wr_valid && o_host_wr_ready) begin
            {job_host_q, job_two_q, job_hi_q} <= 3'h6;
            job_word_q <= i_host_wr_word;
            o_buffer_data <= i_host_wr_word[7:0];
            bstate_q <= DKC_WSET;
          end else begin
            o_host_wr_ready <= 1'b1;
          end
        end
        DKC_WSET: begin
          o_buffer_data_oe <= 1'b1;
          o_buffer_write_enable_n <= 1'b0;
          bstate_q <= DKC_WPULSE;
        end
        DKC_WPULSE: begin
          bcnt_q <= bcnt_q + 3'h1;
          if (bcnt_q == dkc_pkg::BUF_WR_CYCLES - 3'h1) begin
            o_buffer_write_enable_n <= 1'b1;
            bstate_q <= DKC_WHOLD;
          end
        end
        DKC_WHOLD: begin
          bcnt_q <= 3'h0;
          o_buffer_data_oe <= 1'b0;
          buf_addr_q <= buf_addr_q + 16'h0001;
          if (job_two_q && !job_hi_q) begin
            job_hi_q <= 1'b1;
            o_buffer_data <= job_word_q[15:8];
            bstate_q <= DKC_WSET;
          end else begin
            bstate_q <= DKC_IDLE;
          end
        end
        DKC_RSTROBE: begin
          bcnt_q <= bcnt_q + 3'h1;
          if (bcnt_q == dkc_pkg::BUF_RD_CYCLES - 3'h1) begin
            bcnt_q <= 3'h0;
            o_buffer_output_enable_n <= 1'b1;
            buf_addr_q <= buf_addr_q + 16'h0001;
            if (!job_host_q) begin
              buf_rbyte_q <= bd_s2_q;
              bstate_q <= DKC_IDLE;
            end else if (!job_hi_q) begin
              job_word_q[7:0] <= bd_s2_q;
              job_hi_q <= 1'b1;
              bstate_q <= DKC_WHOLD;
            end else begin
              o_host_rd_word <= {bd_s2_q, job_word_q[7:0]};
              o_host_rd_valid <= 1'b1;
              bstate_q <= DKC_IDLE;
            end
          end
        end
        default: bstate_q <= DKC_IDLE;
      endcase
      if (bstate_q == DKC_WHOLD && job_host_q && !o_buffer_data_oe) begin
        buf_addr_q <= buf_addr_q;
        o_buffer_output_enable_n <= 1'b0;
        bstate_q <= DKC_RSTROBE;
      end
      if (wr_strobe && laddr_q == dkc_pkg::REG_BUF_DATA) begin
        mcu_wbyte_q <= ad_s2_q;
        mcu_wr_pend_q <= 1'b1;
      end
      if (wr_strobe && laddr_q == dkc_pkg::REG_BUF_CMD && ad_s2_q[dkc_pkg::BUF_CMD_READ]) begin
        mcu_rd_pend_q <= 1'b1;
      end
      if (i_host_rd_req) begin
        host_rd_pend_q <= 1'b1;
      end
      if (wr_strobe && laddr_q == dkc_pkg::REG_BUF_ADDR_LO) begin
        buf_addr_q[7:0] <= ad_s2_q;
      end
      if (wr_strobe && laddr_q == dkc_pkg::REG_BUF_ADDR_HI) begin
        buf_addr_q[15:8] <= ad_s2_q;
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      o_buffer_addr <= 16'h0000;
      o_upper_bank_select_n <= 1'b1;
    end else if (i_ce) begin
      o_buffer_addr <= buf_addr_q;
      o_upper_bank_select_n <= !buf_addr_q[15];
    end
  end

  // ---------------------------------------------------------------
  // Clock and reset outputs
  // ---------------------------------------------------------------
  logic [6:0] rst_cnt_q;

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      rst_cnt_q <= dkc_pkg::RST_OUT_CYCLES;
      o_reset_output <= 1'b1;
    end else if (i_ce) begin
      if (wr_strobe && laddr_q == dkc_pkg::REG_RESET_CMD) begin
        rst_cnt_q <= dkc_pkg::RST_OUT_CYCLES;
        o_reset_output <= 1'b1;
      end else if (rst_cnt_q != 7'h00) begin
        rst_cnt_q <= rst_cnt_q - 7'h01;
      end else begin
        o_reset_output <= 1'b0;
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      o_half_rate_clock <= 1'b0;
    end else if (i_ce) begin
      o_half_rate_clock <= !o_half_rate_clock;
    end
  end

endmodule

/* File: verilog/dkc_pkg.sv */
package dkc_pkg;
  // ---------------------------------------------------------------
  // Register indices on the microcontroller bus
  // ---------------------------------------------------------------
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h01;
  localparam logic [7:0] REG_BUF_ADDR_LO = 8'h02;
  localparam logic [7:0] REG_BUF_ADDR_HI = 8'h03;
  localparam logic [7:0] REG_BUF_DATA = 8'h04;
  localparam logic [7:0] REG_BUF_CMD = 8'h05;
  localparam logic [7:0] REG_DISK_TX = 8'h06;
  localparam logic [7:0] REG_DISK_RX = 8'h07;
  localparam logic [7:0] REG_INT_EN = 8'h08;
  localparam logic [7:0] REG_CRC_LO = 8'h09;
  localparam logic [7:0] REG_CRC_HI = 8'h0a;
  localparam logic [7:0] REG_RESET_CMD = 8'h0b;
  localparam logic [7:0] REG_LAST = 8'h0b;

  // ---------------------------------------------------------------
  // Control, interrupt enable and buffer command register fields
  // ---------------------------------------------------------------
  localparam int CTRL_ESDI = 0;
  localparam int CTRL_READ_GATE = 1;
  localparam int CTRL_WRITE_GATE = 2;
  localparam int CTRL_MARK_WRITE = 3;
  localparam int CTRL_POLY_SEL = 4;
  localparam int CTRL_CRC_EN = 5;
  localparam int CTRL_MARK_EN0 = 6;
  localparam int CTRL_MARK_EN1 = 7;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam int INT_EN_RX = 0;
  localparam int INT_EN_TX = 1;
  localparam logic [1:0] INT_EN_RESET = 2'h0;
  localparam int BUF_CMD_READ = 0;

  // ---------------------------------------------------------------
  // Checksum polynomials and seed
  // ---------------------------------------------------------------
  localparam logic [15:0] POLY_CCITT = 16'h1021;
  localparam logic [15:0] POLY_ALT = 16'h8005;
  localparam logic [15:0] CRC_SEED = 16'hffff;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_PS = 5000;
  localparam int RST_OUT_HALF_CYCLES = 24;
  localparam logic [6:0] RST_OUT_CYCLES = 7'(2 * RST_OUT_HALF_CYCLES);
  localparam logic [2:0] WCLK_HALF_CYCLES = 3'h7;
  localparam int BUF_STROBE_NS = 20;
  localparam logic [2:0] BUF_WR_CYCLES = 3'((BUF_STROBE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
  localparam logic [2:0] BUF_RD_CYCLES = 3'h6;
endpackage

/* File: verilog/dkc_top_note.sv */
`timescale 1ns/1ps

/* File: dv/dkc_chk.sv */
`timescale 1ns/1ps
module dkc_chk (
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic i_ce,
  input wire logic i_mcu_read_n,
  input wire logic i_program_fetch_strobe_n,
  input wire logic o_mcu_muxed_addr_data_oe,
  input wire logic [15:0] o_buffer_addr,
  input wire logic o_upper_bank_select_n,
  input wire logic o_buffer_write_enable_n,
  input wire logic o_buffer_output_enable_n,
  input wire logic o_buffer_data_oe,
  input wire logic o_disk_write_gate,
  input wire logic o_mark_sync_pin_oe,
  input wire logic o_mark_gate_pin,
  input wire logic o_reset_output,
  input wire logic o_half_rate_clock
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_reset);
  logic rd_ok;
  logic [7:0] rc_q;
  assign rd_ok = !i_mcu_read_n && i_program_fetch_strobe_n;
  // Cycles the reset output has stood high
  always_ff @(posedge i_clk) begin
    if (i_reset || !o_reset_output) rc_q <= 8'h00;
    else if (rc_q != 8'hff) rc_q <= rc_q + 8'h01;
  end
  sequence s_wr_pulse;
    !o_buffer_write_enable_n [*4] ##1 o_buffer_write_enable_n;
  endsequence
  sequence s_rd_pulse;
    !o_buffer_output_enable_n [*6] ##1 o_buffer_output_enable_n;
  endsequence
  a_bank_inverse: assert property (o_upper_bank_select_n == !o_buffer_addr[15])
    else $error("bank select not inverse of top address bit");
  a_strobes_apart: assert property (!(!o_buffer_write_enable_n && !o_buffer_output_enable_n))
    else $error("buffer strobes low together");
  a_write_drives: assert property (!o_buffer_write_enable_n |-> o_buffer_data_oe)
    else $error("buffer write without data drive");
  a_read_no_drive: assert property (!o_buffer_output_enable_n |-> !o_buffer_data_oe)
    else $error("buffer data driven during read");
  a_write_pulse: assert property ($fell(o_buffer_write_enable_n) |-> s_wr_pulse)
    else $error("buffer write pulse length wrong");
  a_read_pulse: assert property ($fell(o_buffer_output_enable_n) |-> s_rd_pulse)
    else $error("buffer read pulse length wrong");
  a_half_toggle: assert property ($rose(o_half_rate_clock) && i_ce |=> $fell(o_half_rate_clock))
    else $error("half rate clock high too long");
  a_reset_length: assert property ($fell(o_reset_output) |-> rc_q >= 8'h30)
    else $error("reset output too short");
  a_mark_gate_write: assert property (o_mark_gate_pin && !o_mark_sync_pin_oe |-> o_disk_write_gate)
    else $error("legacy mark gate outside write");
  a_read_drive_cause: assert property ($rose(o_mcu_muxed_addr_data_oe) |-> $past(rd_ok, 3))
    else $error("data bus driven without valid read");
endmodule
bind dkc_top dkc_chk i_dkc_chk (.i_clk, .i_reset, .i_ce, .i_mcu_read_n, .i_program_fetch_strobe_n,
  .o_mcu_muxed_addr_data_oe, .o_buffer_addr, .o_upper_bank_select_n, .o_buffer_write_enable_n,
  .o_buffer_output_enable_n, .o_buffer_data_oe, .o_disk_write_gate, .o_mark_sync_pin_oe,
  .o_mark_gate_pin, .o_reset_output, .o_half_rate_clock);

/* File: dv/dkc_disk_model.sv */
`timescale 1ns/1ps
module dkc_disk_model (
  input wire logic i_gate,
  output logic o_clk,
  output logic o_data,
  output logic o_sync
);
  initial begin
    o_clk = 1'b0;
    o_data = 1'b0;
    o_sync = 1'b0;
    #1.3;
    forever begin
      #62.5;
      o_clk = ~o_clk;
    end
  end
  task frame(input logic [15:0] w);
    int i;
    repeat (4) @(negedge o_clk);
    o_sync = i_gate;
    @(negedge o_clk);
    for (i = 15; i >= 0; i--) begin
      o_data = w[i];
      @(negedge o_clk);
    end
    o_sync = 1'b0;
    o_data = ~o_data;
  endtask
endmodule

/* File: dv/dkc_top_tb_top.sv */
`timescale 1ns/1ps
module dkc_top_tb_top;
  logic clk = 1'b0, rst = 1'b1, ale = 1'b0, psn = 1'b1, rd_n = 1'b1, wr_n = 1'b1;
  logic [7:0] ad = 8'h00, pat = 8'h00;
  logic [7:0] ram [0:15];
  logic [7:0] ad_w, bd_w, o_ad, o_bd, la;
  logic oe_ad, we_n, oe_n, wc, ws, rg, wg, ms, ms_oe, mg, ro, irq_n, bank_n, m_clk, m_dat, m_sync, sync_w;
  logic [15:0] ba;
  logic hv = 1'b0, hq = 1'b0, hrdy, hval;
  logic [15:0] hw = 16'h5a3c, hr;
  int n_fail = 0, compares = 0;
  always #2.5 clk = ~clk;
  always @(posedge clk) begin
    pat <= pat + 8'h01;
    if (!we_n) ram[ba[3:0]] <= o_bd;
  end
  assign ad_w = oe_ad ? o_ad : ad;
  assign bd_w = !oe_n ? ram[ba[3:0]] : pat;
  assign sync_w = ms_oe ? ms : m_sync;
  dkc_top i_dkc_top (.i_clk(clk), .i_reset(rst), .i_ce(1'b1), .i_mcu_muxed_addr_data(ad_w),
    .o_mcu_muxed_addr_data(o_ad), .o_mcu_muxed_addr_data_oe(oe_ad), .o_mcu_latched_addr(la),
    .i_address_latch_strobe(ale), .i_program_fetch_strobe_n(psn), .i_mcu_read_n(rd_n), .i_mcu_write_n(wr_n),
    .o_mcu_interrupt_n(irq_n), .i_buffer_data(bd_w), .o_buffer_data(o_bd), .o_buffer_data_oe(),
    .o_buffer_addr(ba), .o_upper_bank_select_n(bank_n), .o_buffer_write_enable_n(we_n),
    .o_buffer_output_enable_n(oe_n), .i_host_wr_valid(hv), .i_host_wr_word(hw), .o_host_wr_ready(hrdy),
    .i_host_rd_req(hq), .o_host_rd_word(hr), .o_host_rd_valid(hval), .o_disk_read_gate(rg),
    .o_disk_write_gate(wg), .i_disk_read_clock(m_clk), .i_disk_read_serial(m_dat), .o_disk_write_clock(wc),
    .o_disk_write_serial(ws), .i_mark_sync_pin(sync_w), .o_mark_sync_pin(ms), .o_mark_sync_pin_oe(ms_oe),
    .o_mark_gate_pin(mg), .o_reset_output(ro), .o_half_rate_clock());
  dkc_disk_model i_dkc_disk_model (.i_gate(rg), .o_clk(m_clk), .o_data(m_dat), .o_sync(m_sync));
  task results();
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task chk(input string n, input logic [15:0] e, s);
    compares++;
    if (s !== e) begin
      n_fail++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask
  task cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  task mcu(input logic [7:0] a, d, input logic w, p, output logic [7:0] q);
    int k;
    ad <= a;
    ale <= 1'b1;
    psn <= p;
    cyc(3);
    ale <= 1'b0;
    cyc(5);
    chk("latched_addr", 16'(a), 16'(la));
    if (w) begin
      ad <= d;
      wr_n <= 1'b0;
      cyc(4);
      wr_n <= 1'b1;
      cyc(6);
    end else begin
      ad <= ~a;
      rd_n <= 1'b0;
      for (k = 0; k < 20 && oe_ad !== 1'b1; k++) cyc(1);
      if (k == 20) begin
        n_fail++;
        results();
      end
      q = o_ad;
      rd_n <= 1'b1;
      cyc(8);
    end
    psn <= 1'b1;
  endtask
  task wr(input logic [7:0] a, d);
    logic [7:0] q;
    mcu(a, d, 1'b1, 1'b1, q);
  endtask
  task rd(input string n, input logic [7:0] a, e);
    logic [7:0] q;
    mcu(a, 8'h00, 1'b0, 1'b1, q);
    chk(n, 16'(e), 16'(q));
  endtask
  task t_reset();
    int k;
    cyc(10);
    rst <= 1'b0;
    for (k = 0; k < 200 && ro !== 1'b0; k++) cyc(1);
    chk("reset_len", 16'h0001, 16'(k >= 48 && k < 200));
  endtask
  task t_regs();
    logic [7:0] q;
    wr(dkc_pkg::REG_CTRL, 8'h06);
    chk("read_gate", 16'h0001, 16'(rg));
    chk("write_gate", 16'h0001, 16'(wg));
    mcu(dkc_pkg::REG_CTRL, 8'hff, 1'b1, 1'b0, q);
    rd("ctrl", dkc_pkg::REG_CTRL, 8'h06);
  endtask
  task t_buffer();
    wr(dkc_pkg::REG_BUF_ADDR_HI, 8'h80);
    wr(dkc_pkg::REG_BUF_ADDR_LO, 8'h03);
    chk("bank_n", 16'h0000, 16'(bank_n));
    wr(dkc_pkg::REG_BUF_DATA, 8'ha5);
    cyc(20);
    chk("ram_byte", 16'h00a5, 16'(ram[3]));
    chk("buf_addr", 16'h8004, ba);
    wr(dkc_pkg::REG_BUF_ADDR_HI, 8'h00);
    wr(dkc_pkg::REG_BUF_ADDR_LO, 8'h03);
    chk("bank_n", 16'h0001, 16'(bank_n));
    wr(dkc_pkg::REG_BUF_CMD, 8'h01);
    cyc(20);
    rd("buf_read", dkc_pkg::REG_BUF_DATA, 8'ha5);
  endtask
  task t_marks();
    wr(dkc_pkg::REG_CTRL, 8'h0c);
    chk("mark_gate", 16'h0001, {14'h0, ms_oe, mg});
    wr(dkc_pkg::REG_CTRL, 8'h41);
    chk("mark_en0", 16'h0006, {13'h0, ms_oe, ms, mg});
    wr(dkc_pkg::REG_CTRL, 8'h81);
    chk("mark_en1", 16'h0005, {13'h0, ms_oe, ms, mg});
  endtask
  task t_host();
    int k;
    wr(dkc_pkg::REG_BUF_ADDR_LO, 8'h05);
    hv <= 1'b1;
    cyc(1);
    for (k = 0; k < 20 && hrdy !== 1'b1; k++) cyc(1);
    hv <= 1'b0;
    cyc(20);
    chk("host_lo", 16'h003c, 16'(ram[5]));
    chk("host_hi", 16'h005a, 16'(ram[6]));
    wr(dkc_pkg::REG_BUF_ADDR_LO, 8'h05);
    hq <= 1'b1;
    cyc(1);
    hq <= 1'b0;
    for (k = 0; k < 40 && hval !== 1'b1; k++) cyc(1);
    chk("host_word", 16'h5a3c, hr);
  endtask
  task t_dread();
    wr(dkc_pkg::REG_INT_EN, 8'h01);
    wr(dkc_pkg::REG_CTRL, 8'h02);
    i_dkc_disk_model.frame(16'ha13c);
    cyc(10);
    chk("irq_n", 16'h0000, 16'(irq_n));
    rd("rx_byte", dkc_pkg::REG_DISK_RX, 8'h3c);
    chk("irq_n", 16'h0001, 16'(irq_n));
  endtask
  task t_dwrite();
    logic [7:0] sh;
    logic p;
    int k;
    sh = 8'h00;
    p = 1'b0;
    wr(dkc_pkg::REG_DISK_TX, 8'hc5);
    wr(dkc_pkg::REG_CTRL, 8'h04);
    for (k = 0; k < 800 && sh !== 8'hc5; k++) begin
      cyc(1);
      if (wc && !p) sh = {sh[6:0], ws};
      p = wc;
    end
    chk("write_serial", 16'h00c5, 16'(sh));
  endtask
  initial begin
    t_reset();
    t_regs();
    t_buffer();
    t_host();
    t_marks();
    t_dread();
    t_dwrite();
    results();
  end
endmodule
